// ---- rtl/cad_decoder.sv ----
// coprocessor address decoder top
// Summary of operation
// - each opcode spans 1024 addresses, 32x32 operands
// - opcode sets block base, operands pick element
// - destination number on address bits 6..2
// - source-1 split across bits 9..7 and 1..0
// - source-1 zero takes operand from data bus
// - destination zero is ordinary register zero
// - register-only ops start on any access size
// - every hitting bus cycle is one instruction
// - block moves read or write step destinations
// - act only on select range c000 to c1ff
// - six bits below select give the opcode
// - source-1 low bits on address bits 1..0
`timescale 1ns/1ps
module cad_decoder
  import cad_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // host bus cycle, one strobe per cycle from same-clock logic
  input wire logic I_CYCLE_VALID,
  input wire logic I_CYCLE_WRITE,
  input wire logic [ADDR_W-1:0] I_CYCLE_ADDR,
  input wire logic [DATA_W-1:0] I_CYCLE_DATA,
  // decoded instruction
  output logic O_ISSUE,
  output logic O_ISSUE_WRITE,
  output logic [5:0] O_OPCODE,
  output logic [4:0] O_FIRST_SOURCE_FIELD,
  output logic [4:0] O_DEST_OPERAND_FIELD,
  output logic O_SRC1_BUS_OPERAND,
  output logic [DATA_W-1:0] O_BUS_DATA
);
  // fields from the address splitter
  logic hit;
  logic [5:0] opcode;
  logic [4:0] src1;
  logic [4:0] dest;
  logic src1_bus;
  // one host cycle taken at this edge
  logic take;
  // issue sequencing
  cad_state_type state;
  cad_state_type next_state;
  logic issue;
  logic next_issue;
  // fields held until the next taken cycle
  logic issue_write;
  logic next_issue_write;
  logic [5:0] opc_q;
  logic [5:0] next_opc_q;
  logic [4:0] src1_q;
  logic [4:0] next_src1_q;
  logic [4:0] dest_q;
  logic [4:0] next_dest_q;
  logic bus_q;
  logic next_bus_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] next_data_q;

  // field extraction is pure wiring; all timing lives in this module
  cad_field_split u_split (
    .i_addr(I_CYCLE_ADDR),
    .o_hit(hit),
    .o_opcode(opcode),
    .o_src1(src1),
    .o_dest(dest),
    .o_src1_bus(src1_bus)
  );

  // no transfer size input: any access size starts the op
  always_comb begin
    take = 1'h0;
    if (I_CYCLE_VALID && hit) begin
      // each cycle is its own instruction, so split cycles issue twice
      take = 1'h1;
    end
  end

  // one pulse per taken cycle; back-to-back cycles keep it high
  always_comb begin
    next_state = state;
    case (state)
      CAD_IDLE: begin
        if (take) begin
          next_state = CAD_ISSUE;
        end
      end
      CAD_ISSUE: begin
        if (!take) begin
          next_state = CAD_IDLE;
        end
      end
      default: begin
        next_state = CAD_IDLE;
      end
    endcase
    next_issue = (next_state == CAD_ISSUE);
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      state <= CAD_IDLE;
      issue <= FLAG_RST;
    end else begin
      state <= next_state;
      issue <= next_issue;
    end
  end

  // direction of the issuing cycle; reads and writes both decode
  always_comb begin
    next_issue_write = issue_write;
    if (take) begin
      next_issue_write = I_CYCLE_WRITE;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      issue_write <= FLAG_RST;
    end else begin
      issue_write <= next_issue_write;
    end
  end

  // opcode picks the 1024-address block
  always_comb begin
    next_opc_q = opc_q;
    if (take) begin
      next_opc_q = opcode;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      opc_q <= OPC_RST;
    end else begin
      opc_q <= next_opc_q;
    end
  end

  // source-1 register number, rejoined from its two address pieces
  always_comb begin
    next_src1_q = src1_q;
    if (take) begin
      next_src1_q = src1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      src1_q <= REG_RST;
    end else begin
      src1_q <= next_src1_q;
    end
  end

  // destination zero has no special meaning, unlike source-1 zero
  always_comb begin
    next_dest_q = dest_q;
    if (take) begin
      next_dest_q = dest;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      dest_q <= REG_RST;
    end else begin
      dest_q <= next_dest_q;
    end
  end

  // marks an operand that came over the host data bus
  always_comb begin
    next_bus_q = bus_q;
    if (take) begin
      next_bus_q = src1_bus;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      bus_q <= FLAG_RST;
    end else begin
      bus_q <= next_bus_q;
    end
  end

  // zeroed otherwise, so stale bus values never look like operands
  always_comb begin
    next_data_q = data_q;
    if (take) begin
      if (src1_bus) begin
        next_data_q = I_CYCLE_DATA;
      end else begin
        next_data_q = DATA_RST;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      data_q <= DATA_RST;
    end else begin
      data_q <= next_data_q;
    end
  end

  // every output is a flop, so no decode path reaches the pins
  assign O_ISSUE = issue;
  assign O_ISSUE_WRITE = issue_write;
  assign O_OPCODE = opc_q;
  assign O_FIRST_SOURCE_FIELD = src1_q;
  assign O_DEST_OPERAND_FIELD = dest_q;
  assign O_SRC1_BUS_OPERAND = bus_q;
  assign O_BUS_DATA = data_q;
endmodule // cad_decoder

// ---- rtl/cad_pkg.sv ----
// package of constants for the coprocessor address decoder
package cad_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SEL_HI = 31;
  localparam int SEL_LO = 16;
  localparam logic [15:0] SEL_MIN = 16'hc000;
  localparam logic [15:0] SEL_MAX = 16'hc1ff;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam int SRC1_HI_HI = 9;
  localparam int SRC1_HI_LO = 7;
  localparam int DEST_HI = 6;
  localparam int DEST_LO = 2;
  localparam int SRC1_LO_HI = 1;
  localparam int SRC1_LO_LO = 0;
  localparam int BLOCK_SIZE = 1024;
  localparam logic [4:0] SRC1_BUS_CODE = 5'h00;
  localparam logic [5:0] OPC_RST = 6'h00;
  localparam logic [4:0] REG_RST = 5'h00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic FLAG_RST = 1'h0;
  typedef enum logic [1:0] {
    CAD_IDLE = 2'b01,
    CAD_ISSUE = 2'b10
  } cad_state_type;
endpackage

// ---- rtl/cad_field_split.sv ----
// splits one bus address into coprocessor instruction fields
`timescale 1ns/1ps
module cad_field_split
  import cad_pkg::*;
(
  // address in
  input wire logic [ADDR_W-1:0] i_addr,
  // fields out
  output logic o_hit,
  output logic [5:0] o_opcode,
  output logic [4:0] o_src1,
  output logic [4:0] o_dest,
  output logic o_src1_bus
);
  logic [15:0] sel;
  always_comb begin
    sel = i_addr[SEL_HI:SEL_LO];
    o_hit = (sel >= SEL_MIN) && (sel <= SEL_MAX);
    o_opcode = i_addr[OPC_HI:OPC_LO];
    // split field keeps doubleword stepping on the destination only
    o_src1 = {i_addr[SRC1_HI_HI:SRC1_HI_LO], i_addr[SRC1_LO_HI:SRC1_LO_LO]};
    o_dest = i_addr[DEST_HI:DEST_LO];
    o_src1_bus = (o_src1 == SRC1_BUS_CODE);
  end
endmodule // cad_field_split

// ---- testbench/cad_asserts.sv ----
// decoder port checker
`timescale 1ns/1ps
module cad_asserts import cad_pkg::*; (input wire logic I_CORE_CLK, I_RESET, I_CYCLE_VALID,
  I_CYCLE_WRITE, O_ISSUE, O_ISSUE_WRITE, O_SRC1_BUS_OPERAND,
  input wire logic [31:0] I_CYCLE_ADDR, I_CYCLE_DATA, O_BUS_DATA,
  input wire logic [5:0] O_OPCODE,
  input wire logic [4:0] O_FIRST_SOURCE_FIELD, O_DEST_OPERAND_FIELD);
  logic [31:0] a, d;
  logic w;
  wire h = I_CYCLE_VALID && I_CYCLE_ADDR[31:16] inside {[SEL_MIN:SEL_MAX]};
  wire [4:0] s = {a[9:7], a[1:0]};
  always_ff @(posedge I_CORE_CLK) {a, d, w} <= {I_CYCLE_ADDR, I_CYCLE_DATA, I_CYCLE_WRITE};
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  hit_issue_a: assert property (h |=> O_ISSUE) else $error("no issue");
  miss_quiet_a: assert property (!h |=> !O_ISSUE) else $error("stray");
  miss_hold_a: assert property (!h |=> $stable(O_OPCODE) && $stable(O_BUS_DATA))
    else $error("moved");
  opcode_field_a: assert property (h |=> O_OPCODE == a[15:10]) else $error("op");
  dest_field_a: assert property (h |=> O_DEST_OPERAND_FIELD == a[6:2])
    else $error("dst");
  src_field_a: assert property (h |=> O_FIRST_SOURCE_FIELD == s)
    else $error("src");
  bus_src_a: assert property (h |=> O_SRC1_BUS_OPERAND == (s == 5'h0)
    && O_BUS_DATA == (s == 5'h0 ? d : 32'h0)) else $error("bus");
  write_dir_a: assert property (h |=> O_ISSUE_WRITE == w) else $error("dir");
endmodule // cad_asserts
bind cad_decoder cad_asserts chk (
  .I_CORE_CLK(I_CORE_CLK),
  .I_RESET(I_RESET),
  .I_CYCLE_VALID(I_CYCLE_VALID),
  .I_CYCLE_WRITE(I_CYCLE_WRITE),
  .O_ISSUE(O_ISSUE),
  .O_ISSUE_WRITE(O_ISSUE_WRITE),
  .O_SRC1_BUS_OPERAND(O_SRC1_BUS_OPERAND),
  .I_CYCLE_ADDR(I_CYCLE_ADDR),
  .I_CYCLE_DATA(I_CYCLE_DATA),
  .O_BUS_DATA(O_BUS_DATA),
  .O_OPCODE(O_OPCODE),
  .O_FIRST_SOURCE_FIELD(O_FIRST_SOURCE_FIELD),
  .O_DEST_OPERAND_FIELD(O_DEST_OPERAND_FIELD)
);

// ---- testbench/cad_host.sv ----
// host bus model
`timescale 1ns/1ps
module cad_host (input wire logic i_clk, output logic o_val = 0, o_wr = 0,
  output logic [31:0] o_adr = 0, o_dat = 0);
  task automatic cyc(input logic [31:0] x, y, input logic z); // one cycle per access
    {o_val, o_wr, o_adr, o_dat} = {1'h1, z, x, y};
    @(posedge i_clk) #1;
  endtask
  task automatic idle; // released address and data invert, never a stale value; o_wr keeps its value
    {o_val, o_adr, o_dat} = {1'h0, ~o_adr, ~o_dat};
    @(posedge i_clk) #1;
  endtask
endmodule // cad_host

// ---- testbench/testbench.sv ----
// self-checking decoder bench
`timescale 1ns/1ps
module testbench;
  import cad_pkg::*;
  logic I_CORE_CLK = 0, I_RESET = 1, v, wr, O_ISSUE, O_ISSUE_WRITE, O_SRC1_BUS_OPERAND;
  logic [5:0] O_OPCODE;
  logic [4:0] O_FIRST_SOURCE_FIELD, O_DEST_OPERAND_FIELD;
  logic [31:0] ad, dt, O_BUS_DATA, r = 32'ha889e80d;
  logic [50:0] e = 51'h0;
  int fail_count = 0, compares = 0, n = 0;
  always #12.5 I_CORE_CLK = ~I_CORE_CLK;
  cad_host host (.i_clk(I_CORE_CLK), .o_val(v), .o_wr(wr), .o_adr(ad), .o_dat(dt));
  cad_decoder dut (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RESET(I_RESET),
    .I_CYCLE_VALID(v),
    .I_CYCLE_WRITE(wr),
    .I_CYCLE_ADDR(ad),
    .I_CYCLE_DATA(dt),
    .O_ISSUE(O_ISSUE),
    .O_ISSUE_WRITE(O_ISSUE_WRITE),
    .O_OPCODE(O_OPCODE),
    .O_FIRST_SOURCE_FIELD(O_FIRST_SOURCE_FIELD),
    .O_DEST_OPERAND_FIELD(O_DEST_OPERAND_FIELD),
    .O_SRC1_BUS_OPERAND(O_SRC1_BUS_OPERAND),
    .O_BUS_DATA(O_BUS_DATA)
  );
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // a miss keeps the held fields and only drops the issue bit
  function automatic logic [50:0] expected(input logic [31:0] x, y, input logic z,
    input logic [50:0] p);
    logic [4:0] f;
    f = {x[9:7], x[1:0]};
    expected = {1'h0, p[49:0]};
    if (x[31:16] inside {[SEL_MIN:SEL_MAX]}) begin
      expected = {1'h1, z, x[15:10], f, x[6:2], f == 5'h0, f == 5'h0 ? y : 32'h0};
    end
  endfunction
  task t(input logic [31:0] x, y, input logic z);
    host.cyc(x, y, z);
    e = expected(x, y, z, e);
    compares++;
    if ({O_ISSUE, O_ISSUE_WRITE, O_OPCODE, O_FIRST_SOURCE_FIELD, O_DEST_OPERAND_FIELD,
      O_SRC1_BUS_OPERAND, O_BUS_DATA} !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t addr %h", $time, x);
    end
  endtask
  task summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge I_CORE_CLK) if (++n == 3000) begin
    fail_count++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge I_CORE_CLK);
    #1 I_RESET = 0;
    host.idle;
    t(32'hc00039a2, r, 1'h1);
    t(32'hc00039a0, r, 1'h1);
    t(32'hc00039a4, ~r, 1'h1);
    t(32'hc0000008, r, 1'h0);
    t(32'hc0000001, ~r, 1'h0);
    t(32'hbfffffff, r, 1'h1);
    t(32'hc1ffffff, r, 1'h1);
    t(32'hc2000000, r, 1'h0);
    for (int i = 0; i < 64; i++) t(32'hc0000480 + 4 * i[4:0], r, i[5]);
    $display("test corners ends");
    for (int i = 0; i < 364; i++) begin
      r = lfsr(r);
      t({i < 64 ? 16'hc000 : (r[31] ? {7'h60, r[24:16]} : r[31:16]),
        i < 64 ? i[5:0] : r[15:10], r[9:0]}, ~r, r[0]);
    end
    $display("test random ends");
    // valid must be low before release, or the stale cycle would be taken
    I_RESET = 1;
    host.idle;
    host.idle;
    I_RESET = 0;
    e = 51'h0;
    t(32'h00000000, r, 1'h1);
    t(32'hc0000009, ~r, 1'h0);
    $display("test reset ends");
    summarize;
  end
endmodule // testbench
